/* File: verilog/twu_consts.vh */
// Register map, field positions, reset values and codes of the timing and watchdog unit
`ifndef TWU_CONSTS_VH
`define TWU_CONSTS_VH

// ****************************************
// Register indices; byte address is index times four
// ****************************************
`define TWU_IDX_CONFIG 24'hFFFF20
`define TWU_IDX_PRESCALER 24'hFFFF22
`define TWU_IDX_PRESET 24'hFFFF24
`define TWU_IDX_CTRL 24'hFFFF26
`define TWU_IDX_WDCOUNT 24'hFFFF28
`define TWU_IDX_MATCH 24'hFFFF2A

// ****************************************
// Field positions
// ****************************************
`define TWU_CFG_LOCK_CFG 0
`define TWU_CFG_LOCK_PRESC 1
`define TWU_CFG_LOCK_PRESET 2
`define TWU_CFG_LOCK_WATCHDOG_COUNT 3
`define TWU_CFG_WD_CLK_SEL 4
`define TWU_CFG_MATCH_EN 5
`define TWU_CTRL_RESTART 0
`define TWU_CTRL_TC 1
`define TWU_CTRL_IRQ_EN 2

// ****************************************
// Reset values and codes
// ****************************************
`define TWU_PRESET_RESET 16'hFFFF
`define TWU_CFG_RESET 6'h00
`define TWU_PRESC_RESET 3'h0
`define TWU_PRESC_MAX_CODE 3'h5
`define TWU_WD_MATCH_VALUE 8'h5C
`define TWU_MODE_ACTIVE 2'h0
`define TWU_MODE_POWER_SAVE 2'h1
`define TWU_MODE_IDLE 2'h2
`define TWU_MODE_HALT 2'h3
`define TWU_RESP_OKAY 2'h0
`define TWU_RESP_SLVERR 2'h2

`endif

/* File: verilog/twu_prescaler.v */
// Slow clock synchroniser, edge detector and power-of-two prescaler
`timescale 1ns/10ps
`include "twu_consts.vh"

module twu_prescaler (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Slow clock pin and control
    input wire slow_clock,
    input wire run_en,
    input wire [2:0] prescale_code,
    // Prescaled tick, one aclk cycle
    output reg prescaled_tick
);

    reg sync1_q;
    reg sync2_q;
    reg last_q;
    reg [4:0] div_q;
    reg [4:0] div_mask;
    wire slow_rise;

    // ****************************************
    // Divider
    // ****************************************
    assign slow_rise = sync2_q & ~last_q;

    always @* begin
        case (prescale_code)
            3'h0: div_mask = 5'h00;
            3'h1: div_mask = 5'h01;
            3'h2: div_mask = 5'h03;
            3'h3: div_mask = 5'h07;
            3'h4: div_mask = 5'h0F;
            default: div_mask = 5'h1F;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            // No false edge straight after reset
            last_q <= 1'b1;
            div_q <= 5'h00;
            prescaled_tick <= 1'b0;
        end else begin
            sync1_q <= slow_clock;
            sync2_q <= sync1_q;
            last_q <= sync2_q;
            // Frozen when halted; a pending tick waits for the resume
            if (run_en) begin
                prescaled_tick <= 1'b0;
            end
            if (run_en && slow_rise) begin
                if ((div_q & div_mask) == div_mask) begin
                    div_q <= 5'h00;
                    prescaled_tick <= 1'b1;
                end else begin
                    div_q <= div_q + 5'h01;
                end
            end
        end
    end

endmodule // twu_prescaler

/* File: verilog/twu_timing_watchdog.v */
// Timing and watchdog unit with AXI4-Lite register slave
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "twu_consts.vh"

module twu_timing_watchdog #(
    parameter ADDR_WIDTH = 32
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Slow clock pin and power mode
    input wire slow_clock,
    input wire [1:0] power_mode,
    // AXI4-Lite write address
    input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [ADDR_WIDTH-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Timer and watchdog outputs
    output reg timer_underflow_pulse,
    output wire timer_interrupt_line,
    output reg watchdog_reset_request
);

    // ****************************************
    // Declarations
    // ****************************************
    reg [5:0] config_q;
    reg [2:0] prescale_code_q;
    reg [15:0] preset_q;
    reg restart_q;
    reg terminal_count_flag_q;
    reg timer_irq_enable_q;
    reg [7:0] wd_count_reg_q;
    reg [15:0] timer_q;
    reg [7:0] wd_counter_q;
    reg wd_running_q;
    reg wd_serviced_q;
    reg [ADDR_WIDTH-1:0] aw_addr_q;
    reg aw_held_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_held_q;
    reg [31:0] rd_data_d;
    reg rd_err_d;
    reg rd_clr_tc_d;
    reg wr_err_d;
    wire prescaled_tick;
    wire tick_en;
    wire run_en;
    wire active;
    wire wr_go;
    wire ar_go;
    wire timer_zero_evt;
    wire wd_tick;
    wire wd_cfg_write;
    wire wd_match_write;
    wire wd_count_write;
    wire wd_service;
    wire wd_bad_match;
    wire wd_late;
    wire wd_too_often;
    wire match_service_enable;
    wire watchdog_clock_select;

    function [ADDR_WIDTH-1:0] byte_addr;
        input [23:0] idx;
        begin
            byte_addr = {{(ADDR_WIDTH-26){1'b0}}, idx, 2'b00};
        end
    endfunction

    assign match_service_enable = config_q[`TWU_CFG_MATCH_EN];
    assign watchdog_clock_select = config_q[`TWU_CFG_WD_CLK_SEL];
    assign run_en = (power_mode != `TWU_MODE_HALT);
    assign tick_en = prescaled_tick & run_en;
    assign active = (power_mode == `TWU_MODE_ACTIVE);

    // ****************************************
    // Prescaler
    // ****************************************
    twu_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .slow_clock(slow_clock),
        .run_en(run_en),
        .prescale_code(prescale_code_q),
        .prescaled_tick(prescaled_tick)
    );

    // ****************************************
    // AXI4-Lite handshakes
    // ****************************************
    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready = ~w_held_q & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;
    assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
    assign ar_go = s_axi_arvalid & ~s_axi_rvalid;

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= {ADDR_WIDTH{1'b0}};
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `TWU_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `TWU_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held_q <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_err_d ? `TWU_RESP_SLVERR : `TWU_RESP_OKAY;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (ar_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_data_d;
                s_axi_rresp <= rd_err_d ? `TWU_RESP_SLVERR : `TWU_RESP_OKAY;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Write decode
    // ****************************************
    wire wr_cfg = wr_go && active && aw_addr_q == byte_addr(`TWU_IDX_CONFIG) && w_strb_q[0]
        && !config_q[`TWU_CFG_LOCK_CFG];
    wire wr_presc = wr_go && active && aw_addr_q == byte_addr(`TWU_IDX_PRESCALER) && w_strb_q[0]
        && !config_q[`TWU_CFG_LOCK_PRESC];
    wire wr_preset = wr_go && active && aw_addr_q == byte_addr(`TWU_IDX_PRESET)
        && !config_q[`TWU_CFG_LOCK_PRESET];
    wire wr_ctrl = wr_go && active && aw_addr_q == byte_addr(`TWU_IDX_CTRL) && w_strb_q[0]
        && !config_q[`TWU_CFG_LOCK_PRESET];
    wire wr_watchdog_count = wr_go && active && aw_addr_q == byte_addr(`TWU_IDX_WDCOUNT) && w_strb_q[0]
        && !config_q[`TWU_CFG_LOCK_WATCHDOG_COUNT];
    wire wr_match = wr_go && aw_addr_q == byte_addr(`TWU_IDX_MATCH) && w_strb_q[0];

    always @* begin
        wr_err_d = 1'b1;
        case (aw_addr_q)
            byte_addr(`TWU_IDX_CONFIG),
            byte_addr(`TWU_IDX_PRESCALER),
            byte_addr(`TWU_IDX_PRESET),
            byte_addr(`TWU_IDX_CTRL),
            byte_addr(`TWU_IDX_WDCOUNT),
            byte_addr(`TWU_IDX_MATCH): wr_err_d = 1'b0;
            default: wr_err_d = 1'b1;
        endcase
    end

    // ****************************************
    // Read decode; locked or inaccessible reads give zero
    // ****************************************
    always @* begin
        rd_data_d = 32'h00000000;
        rd_err_d = 1'b0;
        rd_clr_tc_d = 1'b0;
        case (s_axi_araddr)
            byte_addr(`TWU_IDX_CONFIG): begin
                if (active && !config_q[`TWU_CFG_LOCK_CFG]) begin
                    rd_data_d[5:0] = config_q;
                end
            end
            byte_addr(`TWU_IDX_PRESCALER): begin
                if (active && !config_q[`TWU_CFG_LOCK_PRESC]) begin
                    rd_data_d[2:0] = prescale_code_q;
                end
            end
            byte_addr(`TWU_IDX_PRESET): begin
                if (active && !config_q[`TWU_CFG_LOCK_PRESET]) begin
                    rd_data_d[15:0] = preset_q;
                end
            end
            byte_addr(`TWU_IDX_CTRL): begin
                if (active && !config_q[`TWU_CFG_LOCK_PRESET]) begin
                    rd_data_d[`TWU_CTRL_RESTART] = restart_q;
                    rd_data_d[`TWU_CTRL_TC] = terminal_count_flag_q;
                    rd_data_d[`TWU_CTRL_IRQ_EN] = timer_irq_enable_q;
                    rd_clr_tc_d = 1'b1;
                end
            end
            byte_addr(`TWU_IDX_WDCOUNT): begin
                if (active && !config_q[`TWU_CFG_LOCK_WATCHDOG_COUNT]) begin
                    rd_data_d[7:0] = wd_count_reg_q;
                end
            end
            byte_addr(`TWU_IDX_MATCH): rd_data_d = 32'h00000000;
            default: rd_err_d = 1'b1;
        endcase
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            config_q <= `TWU_CFG_RESET;
            prescale_code_q <= `TWU_PRESC_RESET;
            preset_q <= `TWU_PRESET_RESET;
            timer_irq_enable_q <= 1'b0;
        end else begin
            if (wr_cfg) begin
                // Lock bits only ever set
                config_q[5:4] <= w_data_q[5:4];
                config_q[3:0] <= config_q[3:0] | w_data_q[3:0];
            end
            if (wr_presc) begin
                prescale_code_q <= w_data_q[2:0];
            end
            if (wr_preset && w_strb_q[0]) begin
                preset_q[7:0] <= w_data_q[7:0];
            end
            if (wr_preset && w_strb_q[1]) begin
                preset_q[15:8] <= w_data_q[15:8];
            end
            if (wr_ctrl) begin
                timer_irq_enable_q <= w_data_q[`TWU_CTRL_IRQ_EN];
            end
        end
    end

    // ****************************************
    // Periodic timer
    // ****************************************
    assign timer_zero_evt = tick_en && !restart_q && timer_q == 16'h0001;
    assign timer_interrupt_line = timer_underflow_pulse & timer_irq_enable_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            timer_q <= `TWU_PRESET_RESET;
            restart_q <= 1'b0;
            terminal_count_flag_q <= 1'b0;
            timer_underflow_pulse <= 1'b0;
        end else begin
            if (tick_en) begin
                if (restart_q || timer_q == 16'h0000) begin
                    timer_q <= preset_q;
                end else begin
                    timer_q <= timer_q - 16'h0001;
                end
                // Held for one whole prescaled period
                timer_underflow_pulse <= timer_zero_evt;
            end
            // A new restart request beats the self clear
            if (wr_ctrl && w_data_q[`TWU_CTRL_RESTART]) begin
                restart_q <= 1'b1;
            end else if (tick_en && restart_q) begin
                restart_q <= 1'b0;
            end
            // Set beats the clear on read
            if (timer_zero_evt) begin
                terminal_count_flag_q <= 1'b1;
            end else if (ar_go && rd_clr_tc_d) begin
                terminal_count_flag_q <= 1'b0;
            end
        end
    end

    // ****************************************
    // Watchdog
    // ****************************************
    assign wd_tick = watchdog_clock_select ? tick_en : timer_zero_evt;
    assign wd_count_write = wr_watchdog_count;
    assign wd_match_write = wr_match && match_service_enable;
    assign wd_bad_match = wd_match_write && w_data_q[7:0] != `TWU_WD_MATCH_VALUE;
    assign wd_service = (wd_count_write && !match_service_enable)
        || (wd_match_write && !wd_bad_match);
    assign wd_cfg_write = wd_count_write || wd_match_write;
    assign wd_late = wd_running_q && wd_tick && !wd_service
        && wd_counter_q <= 8'h01;
    assign wd_too_often = wd_running_q && wd_service && wd_serviced_q && !wd_tick;

    always @(posedge aclk) begin
        if (!aresetn) begin
            wd_count_reg_q <= 8'h00;
            wd_counter_q <= 8'h00;
            wd_running_q <= 1'b0;
            wd_serviced_q <= 1'b0;
            watchdog_reset_request <= 1'b0;
        end else begin
            if (wd_count_write) begin
                wd_count_reg_q <= w_data_q[7:0];
            end
            if (wd_cfg_write) begin
                wd_running_q <= 1'b1;
            end
            if (wd_service || (wd_cfg_write && !wd_running_q)) begin
                // Count write loads its own value, match write the stored one
                wd_counter_q <= wd_count_write ? w_data_q[7:0] : wd_count_reg_q;
                wd_serviced_q <= 1'b1;
            end else if (wd_running_q && wd_tick) begin
                wd_counter_q <= wd_counter_q - 8'h01;
                wd_serviced_q <= 1'b0;
            end
            // Sticky until the device reset takes effect
            if (wd_late || wd_too_often || wd_bad_match) begin
                watchdog_reset_request <= 1'b1;
            end
        end
    end

endmodule // twu_timing_watchdog

/* File: verif/twu_props.sv */
// Port assertions for the timing and watchdog unit
`timescale 1ns/10ps
`include "twu_consts.vh"

module twu_props (
    // Clock, reset and mode
    input wire aclk,
    input wire aresetn,
    input wire [1:0] power_mode,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Timer and watchdog outputs
    input wire timer_underflow_pulse,
    input wire timer_interrupt_line,
    input wire watchdog_reset_request
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ****************************************
    // Timer and watchdog
    // ****************************************
    irq_gate_a: assert property (timer_interrupt_line |-> timer_underflow_pulse)
        else $error("interrupt without timer output");
    reset_sticky_a: assert property (watchdog_reset_request |=> watchdog_reset_request)
        else $error("reset request dropped");
    quiet_start_a: assert property ($rose(aresetn) |->
        !timer_underflow_pulse && !watchdog_reset_request)
        else $error("outputs active after reset");
    halt_freeze_a: assert property ($past(power_mode) == `TWU_MODE_HALT |->
        $stable(timer_underflow_pulse) && $stable(watchdog_reset_request))
        else $error("outputs moved in halt");

    // ****************************************
    // Register bus
    // ****************************************
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    no_accept_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
endmodule // twu_props

bind twu_timing_watchdog twu_props twu_props_i (.aclk(aclk), .aresetn(aresetn),
    .power_mode(power_mode), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_underflow_pulse(timer_underflow_pulse),
    .timer_interrupt_line(timer_interrupt_line),
    .watchdog_reset_request(watchdog_reset_request));

/* File: verif/tb.sv */
// Self-checking bench for the timing and watchdog unit
`timescale 1ns/10ps
`include "twu_consts.vh"
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module tb;
    localparam int H = 3;
    localparam int S = 2 * H;
    localparam [31:0] A_CFG = `TWU_IDX_CONFIG * 4;
    localparam [31:0] A_PSC = `TWU_IDX_PRESCALER * 4;
    localparam [31:0] A_PRE = `TWU_IDX_PRESET * 4;
    localparam [31:0] A_CTL = `TWU_IDX_CTRL * 4;
    localparam [31:0] A_WDC = `TWU_IDX_WDCOUNT * 4;
    localparam [31:0] A_MAT = `TWU_IDX_MATCH * 4;
    logic aclk = 0, aresetn = 0, slow_clock = 0, tup_d = 0;
    logic [1:0] power_mode = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    wire awready, wready, bvalid, arready, rvalid, tup, tirq, wrr;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int error_cnt = 0, n_tests = 0, cyc = 0, sc = 0, last = 0, per = 0, wid = 0, nr = 0;
    logic [1:0] bq[$];
    logic [33:0] rq[$];
    logic [33:0] ex;

    always #2.5 aclk = ~aclk;

    twu_timing_watchdog twu_timing_watchdog_i (.aclk(aclk), .aresetn(aresetn),
        .slow_clock(slow_clock), .power_mode(power_mode), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_underflow_pulse(tup), .timer_interrupt_line(tirq),
        .watchdog_reset_request(wrr));

    // ****************************************
    // Slow clock, timer monitor, scoreboard
    // ****************************************
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        sc <= (sc == H - 1) ? 0 : sc + 1;
        if (sc == H - 1) slow_clock <= ~slow_clock;
        tup_d <= tup;
        if (tup && !tup_d) begin
            per <= cyc - last;
            last <= cyc;
            nr <= nr + 1;
        end
        if (!tup && tup_d) wid <= cyc - last;
        if (bvalid && bready) begin
            ex = bq.pop_front();
            `CHK("bresp", ex[1:0], bresp)
        end
        if (rvalid && rready) begin
            ex = rq.pop_front();
            `CHK("rdata", ex, {rresp, rdata})
        end
        if (cyc == 90000) begin
            error_cnt++;
            close_out;
        end
    end

    task automatic cy(input int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic rise;
        int k;
        k = nr;
        while (nr == k) @(posedge aclk);
    endtask

    task automatic rst;
        aresetn <= 0;
        cy(4);
        aresetn <= 1;
    endtask

    task automatic wr(input [31:0] a, input [31:0] d, input [1:0] e = `TWU_RESP_OKAY);
        bit pa, pw;
        bq.push_back(e);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        pa = 1;
        pw = 1;
        while (pa || pw) begin
            @(posedge aclk);
            if (pa && awready) begin awvalid <= 0; pa = 0; end
            if (pw && wready) begin wvalid <= 0; pw = 0; end
        end
        cy($urandom % 3);
        bready <= 1;
        do @(posedge aclk); while (!bvalid);
        bready <= 0;
    endtask

    task automatic rd(input [31:0] a, input [31:0] d, input [1:0] e = `TWU_RESP_OKAY);
        rq.push_back({e, d});
        araddr <= a;
        arvalid <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        cy($urandom % 3);
        rready <= 1;
        do @(posedge aclk); while (!rvalid);
        rready <= 0;
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        int p, k;
        void'($urandom(32'hcb2c));
        cy(4);
        aresetn <= 1;
        rd(A_CFG, 0);
        rd(A_PSC, 0);
        rd(A_PRE, 32'hFFFF);
        rd(A_CTL, 0);
        rd(A_CFG + 4, 0, `TWU_RESP_SLVERR);
        wr(A_CFG + 4, 0, `TWU_RESP_SLVERR);
        for (int c = 0; c < 6; c++) begin
            p = 1 + $urandom % 4;
            wr(A_PSC, c);
            wr(A_PRE, p);
            wr(A_CTL, 32'h5);
            rise;
            rise;
            rise;
            `CHK("period", ((p + 1) * S) << c, per)
            `CHK("width", S << c, wid)
        end
        `CHK("irq on", 1'b1, tirq)
        rd(A_CTL, 32'h6);
        rd(A_CTL, 32'h4);
        wr(A_CTL, 0);
        rise;
        `CHK("irq off", 1'b0, tirq)
        wr(A_PSC, 0);
        wr(A_PRE, 200);
        wr(A_CTL, 1);
        rise;
        rise;
        cy(2 * S);
        wr(A_PRE, 3);
        rise;
        `CHK("old preset", 201 * S, per)
        rise;
        `CHK("new preset", 4 * S, per)
        power_mode <= `TWU_MODE_POWER_SAVE;
        rd(A_PRE, 0);
        wr(A_PRE, 9);
        power_mode <= `TWU_MODE_IDLE;
        k = nr;
        cy(20 * S);
        `CHK("idle runs", 1'b1, nr > k)
        power_mode <= `TWU_MODE_HALT;
        cy(2);
        k = nr;
        cy(20 * S);
        `CHK("halt stops", k, nr)
        power_mode <= `TWU_MODE_ACTIVE;
        rise;
        rise;
        `CHK("resume", 4 * S, per)
        wr(A_PRE, 200);
        rise;
        rise;
        cy(50 * S);
        wr(A_CTL, 1);
        k = cyc;
        rise;
        `CHK("restart", 1'b1, (cyc - k) inside {[199 * S:203 * S]})
        rd(A_CTL, 32'h2);
        rst;
        wr(A_CFG, 32'h10);
        wr(A_WDC, 10);
        repeat (4) begin
            cy(6 * S);
            wr(A_WDC, 10);
        end
        cy(7 * S);
        `CHK("wd alive", 1'b0, wrr)
        cy(6 * S);
        `CHK("wd late", 1'b1, wrr)
        rst;
        wr(A_PRE, 3);
        wr(A_CTL, 1);
        wr(A_WDC, 3);
        cy(40);
        `CHK("wd on timer", 1'b0, wrr)
        cy(80);
        `CHK("wd timer late", 1'b1, wrr)
        rst;
        wr(A_PSC, 5);
        wr(A_CFG, 32'h10);
        wr(A_WDC, 50);
        wr(A_WDC, 50);
        cy(4);
        `CHK("too often", 1'b1, wrr)
        rst;
        wr(A_PSC, 5);
        wr(A_CFG, 32'h10);
        wr(A_MAT, 32'h12);
        cy(400);
        `CHK("match ignored", 1'b0, wrr)
        wr(A_CFG, 32'h30);
        wr(A_WDC, 4);
        repeat (3) begin
            cy(400);
            wr(A_MAT, 32'h5C);
        end
        `CHK("match ok", 1'b0, wrr)
        wr(A_MAT, 32'h5D);
        cy(4);
        `CHK("bad match", 1'b1, wrr)
        rst;
        wr(A_CFG, 32'h1E);
        wr(A_CFG, 32'h10);
        rd(A_CFG, 32'h1E);
        wr(A_PRE, 5);
        rd(A_PRE, 0);
        wr(A_WDC, 1);
        cy(100);
        `CHK("locked count", 1'b0, wrr)
        wr(A_CFG, 32'h1F);
        wr(A_CFG, 0);
        rd(A_CFG, 0);
        close_out;
    end
endmodule // tb
